// file: inc/rrsao_pkg.sv
package rrsao_pkg;

   // ****************************************
   // Widths and reset values
   // ****************************************
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [3:0] ZERO_NIB = 4'h0;
   localparam int MSB = 7;
   localparam int NIB_W = 4;

   // ****************************************
   // Operations handled here
   // ****************************************
   typedef enum logic [2:0] {
      RRSAO_OP_RETURN_WITH_LITERAL = 3'h0,
      RRSAO_OP_RETURN = 3'h1,
      RRSAO_OP_ROTATE_RIGHT_VIA_CARRY = 3'h2,
      RRSAO_OP_SLEEP = 3'h3,
      RRSAO_OP_LITERAL_MINUS_ACC = 3'h4,
      RRSAO_OP_XOR_IMMEDIATE = 3'h5,
      RRSAO_OP_NONE = 3'h7
   } rrsao_op_t;

   typedef enum logic [1:0] {
      RRSAO_ST_RUN = 2'b00,
      RRSAO_ST_SECOND = 2'b01,
      RRSAO_ST_SLEEP = 2'b10
   } rrsao_state_t;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      rrsao_op_t op;
      logic [DATA_W-1:0] lit;
      logic [ADDR_W-1:0] addr;
      logic dest;
   } rrsao_instr_t;

   typedef struct packed {
      logic carry;
      logic halfCarry;
      logic zero;
      logic powerdownFlagN;
      logic dogExpiryFlagN;
   } rrsao_status_t;

   localparam rrsao_status_t STATUS_RST = '{carry: 1'b0, halfCarry: 1'b0,
      zero: 1'b0, powerdownFlagN: 1'b1, dogExpiryFlagN: 1'b1};

endpackage : rrsao_pkg

// file: logic/rrsao_core.sv
// Contract
// - Return-with-literal loads immediate into accumulator; flags kept.
// - Return-with-literal loads PC from stack head; takes two cycles.
// - Return pops the stack, loads PC from head, flags kept; two cycles.
// - Rotate right moves operand through carry; only carry flag changes.
// - Rotate result goes to accumulator when dest is 0, file when 1.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep clears powerdown flag, sets expiry flag, other flags kept.
// - After sleep the core halts; instructions stop until wake.
// - Subtract literal minus accumulator; updates carry, half carry, zero.
// - XOR immediate into accumulator; only zero flag changes.
module rrsao_core (
   input wire logic clk,
   input wire logic rst,
   input wire logic instrValid,
   input wire rrsao_pkg::rrsao_instr_t instr,
   input wire logic [7:0] fileRdData,
   input wire logic [12:0] stackHead,
   input wire logic wakeReq,
   output logic [7:0] acc_r,
   output rrsao_pkg::rrsao_status_t status_r,
   output logic fileWe_r,
   output logic [6:0] fileWrAddr_r,
   output logic [7:0] fileWrData_r,
   output logic pcLoad_r,
   output logic [12:0] pcValue_r,
   output logic stackPop_r,
   output logic dogClear_r,
   output logic prescClear_r,
   output logic sleeping_r,
   output logic busy_r
);

   // ****************************************
   // Issue and sequencing
   // ****************************************
   rrsao_pkg::rrsao_state_t state_r;
   rrsao_pkg::rrsao_state_t state_nxt;
   logic accept;
   logic [7:0] rotRes;
   logic rotCarry;
   logic [8:0] subFull;
   logic [4:0] subNib;
   logic [7:0] xorRes;

   // Requests while busy or asleep are dropped, not queued
   assign accept = instrValid && (state_r == rrsao_pkg::RRSAO_ST_RUN);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rrsao_pkg::RRSAO_ST_RUN: begin
            if (accept) begin
               case (instr.op)
                  rrsao_pkg::RRSAO_OP_RETURN_WITH_LITERAL,
                  rrsao_pkg::RRSAO_OP_RETURN: begin
                     state_nxt = rrsao_pkg::RRSAO_ST_SECOND;
                  end
                  rrsao_pkg::RRSAO_OP_SLEEP: begin
                     state_nxt = rrsao_pkg::RRSAO_ST_SLEEP;
                  end
                  default: begin
                     state_nxt = rrsao_pkg::RRSAO_ST_RUN;
                  end
               endcase
            end
         end
         rrsao_pkg::RRSAO_ST_SECOND: begin
            state_nxt = rrsao_pkg::RRSAO_ST_RUN;
         end
         rrsao_pkg::RRSAO_ST_SLEEP: begin
            if (wakeReq) begin
               state_nxt = rrsao_pkg::RRSAO_ST_RUN;
            end
         end
         default: begin
            state_nxt = rrsao_pkg::RRSAO_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= rrsao_pkg::RRSAO_ST_RUN;
         busy_r <= 1'b0;
         sleeping_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         busy_r <= (state_nxt == rrsao_pkg::RRSAO_ST_SECOND);
         sleeping_r <= (state_nxt == rrsao_pkg::RRSAO_ST_SLEEP);
      end
   end

   // ****************************************
   // Datapath
   // ****************************************
   assign rotRes = {status_r.carry, fileRdData[rrsao_pkg::MSB:1]};
   assign rotCarry = fileRdData[0];
   // Borrow-free subtract sets carry, as in two's complement add of -acc
   assign subFull = {1'b0, instr.lit} - {1'b0, acc_r};
   assign subNib = {1'b0, instr.lit[rrsao_pkg::NIB_W-1:0]}
      - {1'b0, acc_r[rrsao_pkg::NIB_W-1:0]};
   assign xorRes = acc_r ^ instr.lit;

   // ****************************************
   // Accumulator and flags
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_r <= rrsao_pkg::ACC_RST;
      end else if (accept) begin
         case (instr.op)
            rrsao_pkg::RRSAO_OP_RETURN_WITH_LITERAL: begin
               acc_r <= instr.lit;
            end
            rrsao_pkg::RRSAO_OP_ROTATE_RIGHT_VIA_CARRY: begin
               if (!instr.dest) begin
                  acc_r <= rotRes;
               end
            end
            rrsao_pkg::RRSAO_OP_LITERAL_MINUS_ACC: begin
               acc_r <= subFull[rrsao_pkg::MSB:0];
            end
            rrsao_pkg::RRSAO_OP_XOR_IMMEDIATE: begin
               acc_r <= xorRes;
            end
            default: begin
               acc_r <= acc_r;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status_r <= rrsao_pkg::STATUS_RST;
      end else if (accept) begin
         case (instr.op)
            rrsao_pkg::RRSAO_OP_ROTATE_RIGHT_VIA_CARRY: begin
               status_r.carry <= rotCarry;
            end
            rrsao_pkg::RRSAO_OP_SLEEP: begin
               status_r.powerdownFlagN <= 1'b0;
               status_r.dogExpiryFlagN <= 1'b1;
            end
            rrsao_pkg::RRSAO_OP_LITERAL_MINUS_ACC: begin
               status_r.carry <= ~subFull[rrsao_pkg::DATA_W];
               status_r.halfCarry <= ~subNib[rrsao_pkg::NIB_W];
               status_r.zero <= (subFull[rrsao_pkg::MSB:0]
                  == rrsao_pkg::ZERO_BYTE);
            end
            rrsao_pkg::RRSAO_OP_XOR_IMMEDIATE: begin
               status_r.zero <= (xorRes == rrsao_pkg::ZERO_BYTE);
            end
            default: begin
               status_r <= status_r;
            end
         endcase
      end
   end

   // ****************************************
   // File write, return and watchdog strobes
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         fileWe_r <= 1'b0;
         fileWrAddr_r <= '0;
         fileWrData_r <= rrsao_pkg::ZERO_BYTE;
      end else begin
         fileWe_r <= accept && instr.dest
            && (instr.op == rrsao_pkg::RRSAO_OP_ROTATE_RIGHT_VIA_CARRY);
         if (accept) begin
            fileWrAddr_r <= instr.addr;
            fileWrData_r <= rotRes;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pcLoad_r <= 1'b0;
         stackPop_r <= 1'b0;
         pcValue_r <= '0;
      end else begin
         // Both returns pop so the head moves to the caller's caller
         pcLoad_r <= (state_nxt == rrsao_pkg::RRSAO_ST_SECOND);
         stackPop_r <= (state_nxt == rrsao_pkg::RRSAO_ST_SECOND);
         if (state_nxt == rrsao_pkg::RRSAO_ST_SECOND) begin
            pcValue_r <= stackHead;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dogClear_r <= 1'b0;
         prescClear_r <= 1'b0;
      end else begin
         dogClear_r <= accept
            && (instr.op == rrsao_pkg::RRSAO_OP_SLEEP);
         prescClear_r <= accept
            && (instr.op == rrsao_pkg::RRSAO_OP_SLEEP);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_ret_lit_acc;
      accept && instr.op == rrsao_pkg::RRSAO_OP_RETURN_WITH_LITERAL
         |=> acc_r == $past(instr.lit) && status_r == $past(status_r);
   endproperty
   a_ret_lit_acc: assert property (p_ret_lit_acc)
      else $error("literal return did not load accumulator");

   property p_ret_two;
      accept && (instr.op == rrsao_pkg::RRSAO_OP_RETURN_WITH_LITERAL
         || instr.op == rrsao_pkg::RRSAO_OP_RETURN)
         |=> pcLoad_r && busy_r && pcValue_r == $past(stackHead)
         ##1 !busy_r && !pcLoad_r;
   endproperty
   a_ret_two: assert property (p_ret_two)
      else $error("return did not take two cycles");

   property p_ret_pop;
      accept && instr.op == rrsao_pkg::RRSAO_OP_RETURN
         |=> stackPop_r && status_r == $past(status_r)
         && acc_r == $past(acc_r);
   endproperty
   a_ret_pop: assert property (p_ret_pop)
      else $error("return did not pop or changed flags");

   property p_rot_flags;
      accept && instr.op == rrsao_pkg::RRSAO_OP_ROTATE_RIGHT_VIA_CARRY
         |=> status_r.carry == $past(fileRdData[0])
         && status_r.zero == $past(status_r.zero)
         && status_r.halfCarry == $past(status_r.halfCarry);
   endproperty
   a_rot_flags: assert property (p_rot_flags)
      else $error("rotate changed wrong flags");

   property p_rot_dest;
      accept && instr.op == rrsao_pkg::RRSAO_OP_ROTATE_RIGHT_VIA_CARRY
         |=> (fileWe_r == $past(instr.dest))
         && ($past(instr.dest) ? fileWrData_r == {$past(status_r.carry),
         $past(fileRdData[7:1])} : acc_r == {$past(status_r.carry),
         $past(fileRdData[7:1])});
   endproperty
   a_rot_dest: assert property (p_rot_dest)
      else $error("rotate result misplaced");

   property p_sleep_dog;
      accept && instr.op == rrsao_pkg::RRSAO_OP_SLEEP
         |=> dogClear_r && prescClear_r ##1 !dogClear_r;
   endproperty
   a_sleep_dog: assert property (p_sleep_dog)
      else $error("sleep did not clear watchdog");

   property p_sleep_flags;
      accept && instr.op == rrsao_pkg::RRSAO_OP_SLEEP
         |=> !status_r.powerdownFlagN && status_r.dogExpiryFlagN
         && status_r.carry == $past(status_r.carry) && sleeping_r;
   endproperty
   a_sleep_flags: assert property (p_sleep_flags)
      else $error("sleep flags wrong");

   property p_sleep_halt;
      sleeping_r && !wakeReq |=> sleeping_r && !fileWe_r && !pcLoad_r
         && acc_r == $past(acc_r);
   endproperty
   a_sleep_halt: assert property (p_sleep_halt)
      else $error("core ran while asleep");

   property p_sub;
      accept && instr.op == rrsao_pkg::RRSAO_OP_LITERAL_MINUS_ACC
         |=> acc_r == $past(instr.lit) - $past(acc_r)
         && status_r.carry == ($past(instr.lit) >= $past(acc_r))
         && status_r.halfCarry
         == ($past(instr.lit[3:0]) >= $past(acc_r[3:0]))
         && status_r.zero == (acc_r == rrsao_pkg::ZERO_BYTE);
   endproperty
   a_sub: assert property (p_sub)
      else $error("subtract result or flags wrong");

   property p_xor;
      accept && instr.op == rrsao_pkg::RRSAO_OP_XOR_IMMEDIATE
         |=> acc_r == ($past(instr.lit) ^ $past(acc_r))
         && status_r.carry == $past(status_r.carry)
         && status_r.zero == (acc_r == rrsao_pkg::ZERO_BYTE);
   endproperty
   a_xor: assert property (p_xor)
      else $error("xor result or flags wrong");

   property p_rot_carry_in;
      accept && instr.op == rrsao_pkg::RRSAO_OP_ROTATE_RIGHT_VIA_CARRY
         && !instr.dest |=> acc_r[7] == $past(status_r.carry);
   endproperty
   a_rot_carry_in: assert property (p_rot_carry_in)
      else $error("rotate did not feed old carry to bit 7");

   c_return: cover property (accept
      && instr.op == rrsao_pkg::RRSAO_OP_RETURN ##2 accept);
   c_sleep_wake: cover property (sleeping_r ##1 wakeReq ##1 !sleeping_r);
   c_sub_zero: cover property (accept
      && instr.op == rrsao_pkg::RRSAO_OP_LITERAL_MINUS_ACC ##1 status_r.zero);
   c_rot_file: cover property (fileWe_r);

endmodule : rrsao_core

// file: verification/tb_rrsao_core.sv
module tb_rrsao_core;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Design and stimulus
   // ****************************************
   logic clk;
   logic rst;
   logic instrValid;
   rrsao_pkg::rrsao_instr_t instr;
   logic [7:0] fileRdData;
   logic [12:0] stackHead;
   logic wakeReq;
   logic [7:0] acc_r;
   rrsao_pkg::rrsao_status_t status_r;
   logic fileWe_r;
   logic [6:0] fileWrAddr_r;
   logic [7:0] fileWrData_r;
   logic pcLoad_r;
   logic [12:0] pcValue_r;
   logic stackPop_r, dogClear_r, prescClear_r, sleeping_r, busy_r;
   int badCount = 0;
   int checks = 0;
   int cyc = 0;
   int acc, cy, hc, zf, pdn, ton, pc;

   rrsao_core dut (.clk(clk), .rst(rst), .instrValid(instrValid),
      .instr(instr), .fileRdData(fileRdData), .stackHead(stackHead),
      .wakeReq(wakeReq), .acc_r(acc_r), .status_r(status_r),
      .fileWe_r(fileWe_r), .fileWrAddr_r(fileWrAddr_r),
      .fileWrData_r(fileWrData_r), .pcLoad_r(pcLoad_r),
      .pcValue_r(pcValue_r), .stackPop_r(stackPop_r),
      .dogClear_r(dogClear_r), .prescClear_r(prescClear_r),
      .sleeping_r(sleeping_r), .busy_r(busy_r));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   task automatic cmpData(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %0t value got %h exp %h", $time, got, exp);
      end
   endtask : cmpData

   task automatic cmpStat(input rrsao_pkg::rrsao_status_t got,
         input rrsao_pkg::rrsao_status_t exp);
      checks++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %0t status got %b exp %b", $time, got, exp);
      end
   endtask : cmpStat

   // Hang guard, well above the under 2500 cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         badCount++;
         $display("BAD %0t run did not finish", $time);
         report_and_stop();
      end
   end

   // ****************************************
   // One instruction against the model
   // ****************************************
   task automatic issue(input int op, input int lit);
      logic [7:0] f;
      logic [6:0] a;
      logic d;
      logic [12:0] sh;
      logic [6:0] pulse;
      int r;
      rrsao_pkg::rrsao_status_t es;
      f = 8'($urandom);
      a = 7'($urandom);
      d = 1'($urandom);
      sh = 13'($urandom);
      pulse = 7'h00;
      r = 0;
      @(posedge clk);
      instrValid <= 1'b1;
      instr <= '{op: rrsao_pkg::rrsao_op_t'(op), lit: lit[7:0], addr: a,
         dest: d};
      fileRdData <= f;
      stackHead <= sh;
      @(posedge clk);
      // Hold a xor in the busy or sleep cycle: it must be dropped
      instrValid <= (op == 0 || op == 1 || op == 3);
      instr.op <= rrsao_pkg::RRSAO_OP_XOR_IMMEDIATE;
      instr.lit <= 8'hff;
      case (op)
         0, 1: begin
            if (op == 0) acc = lit;
            pc = sh;
            pulse = 7'h31;
         end
         2: begin
            r = {cy[0], f[7:1]};
            cy = f[0];
            if (d) pulse = 7'h40;
            else acc = r;
         end
         3: begin
            pdn = 0;
            ton = 1;
            pulse = 7'h0e;
         end
         4: begin
            r = (lit - acc) & 255;
            cy = lit >= acc;
            hc = (lit & 15) >= (acc & 15);
            zf = r == 0;
            acc = r;
         end
         5: begin
            acc = acc ^ lit;
            zf = acc == 0;
         end
         default: ;
      endcase
      es = '{carry: cy[0], halfCarry: hc[0], zero: zf[0],
         powerdownFlagN: pdn[0], dogExpiryFlagN: ton[0]};
      #1;
      cmpData({fileWe_r, pcLoad_r, stackPop_r, dogClear_r, prescClear_r,
         sleeping_r, busy_r}, pulse);
      cmpData(acc_r, acc);
      cmpStat(status_r, es);
      cmpData(pcValue_r, pc);
      if (op == 2 && d) begin
         cmpData({fileWrAddr_r, fileWrData_r}, {a, r[7:0]});
      end
      @(posedge clk);
      instrValid <= 1'b0;
      #1;
      cmpData({busy_r, sleeping_r, acc_r},
         {1'b0, op == 3, acc[7:0]});
      if (op == 3) begin
         repeat (2) @(posedge clk);
         wakeReq <= 1'b1;
         @(posedge clk);
         wakeReq <= 1'b0;
         #1;
         cmpData(sleeping_r, 0);
      end
   endtask : issue

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h540e));
      rst = 1'b1;
      instrValid = 1'b0;
      instr = '0;
      fileRdData = 8'h00;
      stackHead = 13'h0000;
      wakeReq = 1'b0;
      acc = 0;
      cy = 0;
      hc = 0;
      zf = 0;
      pdn = 1;
      ton = 1;
      pc = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      cmpData(acc_r, 0);
      cmpStat(status_r, rrsao_pkg::STATUS_RST);
      // Borrow edges: equal operands, full and nibble borrow
      issue(4, 0);
      issue(5, 8'hff);
      issue(4, 0);
      issue(4, 8'h10);
      for (int i = 0; i < 6; i++) issue(i, 8'h5a);
      // Codes 6 and 7 are taken but must leave all state but the file write address and data alone
      for (int i = 0; i < 400; i++) begin
         issue($urandom % 8, $urandom % 256);
      end
      report_and_stop();
   end

endmodule : tb_rrsao_core
